// *** sbr_params.svh ***
// constants for the sideband register bank and its controller
`ifndef SBR_PARAMS_SVH
`define SBR_PARAMS_SVH
`define SBR_OFF_FIFO 3'h0
`define SBR_OFF_ADDR 3'h1
`define SBR_OFF_STATUS 3'h2
`define SBR_OFF_ARB 3'h4
`define SBR_OFF_DIAG 3'h5
`define SBR_OFF_RXLEN 3'h6
`define SBR_ST_TXERR 0
`define SBR_ST_LINK 1
`define SBR_ST_NEG 2
`define SBR_ST_TXSEEN 3
`define SBR_ST_RXSEEN 4
`define SBR_ST_TRANSMIT_FIFO_EMPTY 5
`define SBR_ST_DNRUN 6
`define SBR_ST_UPRUN 7
`define SBR_ST_WAKE 8
`define SBR_ST_REMOTE 9
`define SBR_ST_CTS 10
`define SBR_DIAG_W 4
`define SBR_RXLEN_W 13
`define SBR_ARB_FREE 8'h00
`define SBC_OFF_TGT 3'h0
`define SBC_OFF_ID 3'h1
`define SBC_OFF_CMD 3'h2
`define SBC_OFF_DATA 3'h3
`define SBC_OFF_OP 3'h4
`define SBC_OFF_STAT 3'h5
`define SBC_OFF_RDATA 3'h6
`define SBC_STAT_BUSY 0
`define SBC_STAT_OWNED 1
`define SBC_STAT_NACK 2
`define SBC_STAT_REFUSED 3
`endif

// *** sbr_pkg.sv ***
// types used by the controller end of the sideband register link and by its bench
package sbr_pkg;
  typedef enum logic [2:0] {
    SBR_OP_WRITE = 3'h0,
    SBR_OP_READ = 3'h1,
    SBR_OP_ACQUIRE = 3'h2,
    SBR_OP_RELEASE = 3'h3,
    SBR_OP_WAIT_DN = 3'h4,
    SBR_OP_WAIT_UP = 3'h5
  } sbr_op_e;
  typedef enum logic [3:0] {
    SBR_ST_IDLE = 4'b0001,
    SBR_ST_REQ = 4'b0010,
    SBR_ST_RESP = 4'b0100,
    SBR_ST_DATA = 4'b1000
  } sbr_state_e;
endpackage

// *** sbr_if.sv ***
// link between the sideband controller and the register bank
`timescale 1ns/1ps
interface sbr_if;
  logic req;
  logic wr;
  logic [6:0] addr;
  logic [2:0] cmd;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic rvalid;
  modport dev (
    input req,
    input wr,
    input addr,
    input cmd,
    input wdata,
    output ack,
    output rdata,
    output rvalid
  );
  modport ctl (
    output req,
    output wr,
    output addr,
    output cmd,
    output wdata,
    input ack,
    input rdata,
    input rvalid
  );
endinterface

// *** sbr_device.sv ***
// sideband register bank: device end of the management link
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "sbr_params.svh"
module sbr_device #(
  parameter logic [6:0] P_ADDR_RST = 7'h10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  sbr_if.dev bus,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [2:0] i_host_cmd,
  input wire logic [15:0] i_host_wdata,
  output logic [15:0] o_host_rdata,
  output logic o_tx_push,
  output logic [7:0] o_tx_byte,
  output logic o_rx_pop,
  input wire logic [7:0] i_rx_byte,
  input wire logic [12:0] i_rx_len,
  input wire logic i_rx_discard,
  input wire logic i_max_coll,
  input wire logic i_reclaim_err,
  input wire logic i_jabber,
  input wire logic i_underrun,
  input wire logic i_link_up,
  input wire logic i_negotiation_done,
  input wire logic i_media_transmitting,
  input wire logic i_fifo_receive_done,
  input wire logic i_transmit_fifo_empty,
  input wire logic i_download_running,
  input wire logic i_upload_running,
  input wire logic i_clear_to_send_packet,
  input wire logic i_wake_mask_mode,
  input wire logic i_wake_detect,
  input wire logic i_power_event_read,
  input wire logic i_pme_enable,
  input wire logic i_pme_ack,
  output logic o_pme_n
);

  logic [6:0] addr_r, addr_nxt;
  logic [7:0] arb_r, arb_nxt;
  logic [`SBR_DIAG_W-1:0] diag_r, diag_nxt;
  logic [`SBR_RXLEN_W-1:0] rxlen_r, rxlen_nxt;
  logic tx_seen_r, tx_seen_nxt;
  logic rx_seen_r, rx_seen_nxt;
  logic wake_r, wake_nxt;
  logic remote_r, remote_nxt;
  logic pme_wake_r, pme_wake_nxt;
  logic pme_n_r, pme_n_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [15:0] host_rdata_r, host_rdata_nxt;
  logic tx_push_r, tx_push_nxt;
  logic [7:0] tx_byte_r, tx_byte_nxt;

  logic sel, s_wr, s_rd;
  logic wr_any;
  logic [2:0] wr_cmd;
  logic [15:0] wr_data;
  logic st_rd;
  logic [15:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign sel = bus.req & (bus.addr == addr_r);
  assign s_wr = sel & bus.wr;
  assign s_rd = sel & ~bus.wr;
  assign bus.ack = sel;
  assign o_rx_pop = s_rd & (bus.cmd == `SBR_OFF_FIFO);

  // link write wins a same-cycle host write; host never reaches fifo
  always_comb begin
    wr_any = 1'b0;
    wr_cmd = bus.cmd;
    wr_data = bus.wdata;
    if (s_wr) begin
      wr_any = 1'b1;
    end else if (i_host_wr && i_host_cmd != `SBR_OFF_FIFO) begin
      wr_any = 1'b1;
      wr_cmd = i_host_cmd;
      wr_data = i_host_wdata;
    end
  end

  assign st_rd = (s_rd & (bus.cmd == `SBR_OFF_STATUS))
    | (i_host_rd & (i_host_cmd == `SBR_OFF_STATUS));

  always_comb begin
    status = 16'h0000;
    status[`SBR_ST_TXERR] = i_max_coll | i_reclaim_err
      | i_jabber | i_underrun;
    status[`SBR_ST_LINK] = i_link_up;
    status[`SBR_ST_NEG] = i_negotiation_done;
    status[`SBR_ST_TXSEEN] = tx_seen_r;
    status[`SBR_ST_RXSEEN] = rx_seen_r;
    status[`SBR_ST_TRANSMIT_FIFO_EMPTY] = i_transmit_fifo_empty;
    status[`SBR_ST_DNRUN] = i_download_running;
    status[`SBR_ST_UPRUN] = i_upload_running;
    status[`SBR_ST_WAKE] = wake_r;
    status[`SBR_ST_REMOTE] = remote_r;
    status[`SBR_ST_CTS] = i_clear_to_send_packet;
  end

  function automatic logic [15:0] reg_view(input logic [2:0] c);
    logic [15:0] v;
    v = 16'h0000;
    unique case (c)
      `SBR_OFF_ADDR: v[6:0] = addr_r;
      `SBR_OFF_STATUS: v = status;
      `SBR_OFF_ARB: v[7:0] = arb_r;
      `SBR_OFF_DIAG: v[`SBR_DIAG_W-1:0] = diag_r;
      `SBR_OFF_RXLEN: v[`SBR_RXLEN_W-1:0] = rxlen_r;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    addr_nxt = addr_r;
    arb_nxt = arb_r;
    diag_nxt = diag_r;
    rxlen_nxt = rxlen_r;
    tx_push_nxt = 1'b0;
    tx_byte_nxt = tx_byte_r;
    if (wr_any) begin
      unique case (wr_cmd)
        `SBR_OFF_FIFO: begin
          tx_push_nxt = 1'b1;
          tx_byte_nxt = wr_data[7:0];
        end
        `SBR_OFF_ADDR: addr_nxt = wr_data[6:0];
        `SBR_OFF_ARB: begin
          if (arb_r == `SBR_ARB_FREE || wr_data[7:0] == `SBR_ARB_FREE) begin
            arb_nxt = wr_data[7:0];
          end
        end
        `SBR_OFF_DIAG: diag_nxt = wr_data[`SBR_DIAG_W-1:0];
        `SBR_OFF_RXLEN: rxlen_nxt = wr_data[`SBR_RXLEN_W-1:0];
        default: ;
      endcase
    end
    if (i_rx_discard) begin
      rxlen_nxt = i_rx_len;
    end
  end

  always_comb begin
    logic wake_clr;
    logic remote_set;
    wake_clr = i_power_event_read
      | (wr_any & (wr_cmd == `SBR_OFF_STATUS) & ~wr_data[`SBR_ST_WAKE]);
    remote_set = wr_any & (wr_cmd == `SBR_OFF_STATUS)
      & wr_data[`SBR_ST_REMOTE];
    tx_seen_nxt = i_media_transmitting | (tx_seen_r & ~st_rd);
    rx_seen_nxt = i_fifo_receive_done | (rx_seen_r & ~st_rd);
    wake_nxt = (i_wake_mask_mode & i_wake_detect)
      | (wake_r & ~wake_clr);
    pme_wake_nxt = (~i_wake_mask_mode & i_wake_detect)
      | (pme_wake_r & ~i_pme_ack);
    remote_nxt = remote_set | (remote_r & ~i_pme_ack);
    pme_n_nxt = ~(i_pme_enable & (remote_r | pme_wake_r));
  end

  always_comb begin
    rvalid_nxt = s_rd;
    rdata_nxt = rdata_r;
    if (s_rd) begin
      if (bus.cmd == `SBR_OFF_FIFO) begin
        rdata_nxt = {8'h00, i_rx_byte};
      end else begin
        rdata_nxt = reg_view(bus.cmd);
      end
    end
    host_rdata_nxt = host_rdata_r;
    if (i_host_rd) begin
      host_rdata_nxt = reg_view(i_host_cmd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      addr_r <= P_ADDR_RST;
      arb_r <= `SBR_ARB_FREE;
      diag_r <= '0;
      rxlen_r <= '0;
      tx_seen_r <= 1'b0;
      rx_seen_r <= 1'b0;
      wake_r <= 1'b0;
      remote_r <= 1'b0;
      pme_wake_r <= 1'b0;
      pme_n_r <= 1'b1;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      host_rdata_r <= 16'h0000;
      tx_push_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      addr_r <= addr_nxt;
      arb_r <= arb_nxt;
      diag_r <= diag_nxt;
      rxlen_r <= rxlen_nxt;
      tx_seen_r <= tx_seen_nxt;
      rx_seen_r <= rx_seen_nxt;
      wake_r <= wake_nxt;
      remote_r <= remote_nxt;
      pme_wake_r <= pme_wake_nxt;
      pme_n_r <= pme_n_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      host_rdata_r <= host_rdata_nxt;
      tx_push_r <= tx_push_nxt;
      tx_byte_r <= tx_byte_nxt;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.rvalid = rvalid_r;
  assign o_host_rdata = host_rdata_r;
  assign o_tx_push = tx_push_r;
  assign o_tx_byte = tx_byte_r;
  assign o_pme_n = pme_n_r;

endmodule

// *** sbr_controller.sv ***
// sideband controller: management-side master of the register link
`timescale 1ns/1ps
`include "sbr_params.svh"
module sbr_controller (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_download_hold_cmd,
  output logic o_upload_hold_cmd,
  sbr_if.ctl bus
);

  sbr_pkg::sbr_state_e st_r, st_nxt;
  sbr_pkg::sbr_op_e op_r, op_nxt;
  logic phase_r, phase_nxt;
  logic [6:0] tgt_r, tgt_nxt;
  logic [7:0] id_r, id_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [15:0] data_r, data_nxt;
  logic owned_r, owned_nxt;
  logic nack_r, nack_nxt;
  logic refused_r, refused_nxt;
  logic [15:0] res_r, res_nxt;
  logic req_r, req_nxt;
  logic bwr_r, bwr_nxt;
  logic [2:0] bcmd_r, bcmd_nxt;
  logic [15:0] bwd_r, bwd_nxt;
  logic dn_r, dn_nxt;
  logic up_r, up_nxt;
  logic [15:0] ord_r, ord_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    sbr_pkg::sbr_op_e new_op;
    new_op = sbr_pkg::sbr_op_e'(i_wdata[2:0]);
    st_nxt = st_r;
    op_nxt = op_r;
    phase_nxt = phase_r;
    tgt_nxt = tgt_r;
    id_nxt = id_r;
    cmd_nxt = cmd_r;
    data_nxt = data_r;
    owned_nxt = owned_r;
    nack_nxt = nack_r;
    refused_nxt = refused_r;
    res_nxt = res_r;
    req_nxt = 1'b0;
    bwr_nxt = bwr_r;
    bcmd_nxt = bcmd_r;
    bwd_nxt = bwd_r;
    dn_nxt = 1'b0;
    up_nxt = 1'b0;
    if (i_wr && st_r == sbr_pkg::SBR_ST_IDLE) begin
      unique case (i_addr)
        `SBC_OFF_TGT: tgt_nxt = i_wdata[6:0];
        `SBC_OFF_ID: id_nxt = i_wdata[7:0];
        `SBC_OFF_CMD: cmd_nxt = i_wdata[2:0];
        `SBC_OFF_DATA: data_nxt = i_wdata;
        `SBC_OFF_OP: begin
          nack_nxt = 1'b0;
          refused_nxt = 1'b0;
          phase_nxt = 1'b0;
          op_nxt = new_op;
          // fifo traffic only once the lock is ours
          if (((new_op == sbr_pkg::SBR_OP_WRITE
                || new_op == sbr_pkg::SBR_OP_READ)
               && cmd_r == `SBR_OFF_FIFO && !owned_r)
              || (new_op == sbr_pkg::SBR_OP_ACQUIRE
               && id_r == `SBR_ARB_FREE)
              || i_wdata[2:0] > 3'h5) begin
            refused_nxt = 1'b1;
          end else begin
            st_nxt = sbr_pkg::SBR_ST_REQ;
            dn_nxt = new_op == sbr_pkg::SBR_OP_WAIT_DN;
            up_nxt = new_op == sbr_pkg::SBR_OP_WAIT_UP;
          end
        end
        default: ;
      endcase
    end
    unique case (st_r)
      sbr_pkg::SBR_ST_IDLE: ;
      sbr_pkg::SBR_ST_REQ: begin
        req_nxt = 1'b1;
        st_nxt = sbr_pkg::SBR_ST_RESP;
        bwr_nxt = 1'b0;
        bcmd_nxt = `SBR_OFF_ARB;
        bwd_nxt = 16'h0000;
        unique case (op_r)
          sbr_pkg::SBR_OP_WRITE: begin
            bwr_nxt = 1'b1;
            bcmd_nxt = cmd_r;
            bwd_nxt = data_r;
          end
          sbr_pkg::SBR_OP_READ: bcmd_nxt = cmd_r;
          sbr_pkg::SBR_OP_ACQUIRE: begin
            bwr_nxt = ~phase_r;
            bwd_nxt = {8'h00, id_r};
          end
          sbr_pkg::SBR_OP_RELEASE: bwr_nxt = 1'b1;
          default: bcmd_nxt = `SBR_OFF_STATUS;
        endcase
      end
      sbr_pkg::SBR_ST_RESP: begin
        st_nxt = sbr_pkg::SBR_ST_IDLE;
        if (!bus.ack) begin
          nack_nxt = 1'b1;
        end else if (!bwr_r) begin
          st_nxt = sbr_pkg::SBR_ST_DATA;
        end else if (op_r == sbr_pkg::SBR_OP_ACQUIRE) begin
          phase_nxt = 1'b1;
          st_nxt = sbr_pkg::SBR_ST_REQ;
        end else if (op_r == sbr_pkg::SBR_OP_RELEASE) begin
          owned_nxt = 1'b0;
        end
      end
      sbr_pkg::SBR_ST_DATA: begin
        if (bus.rvalid) begin
          res_nxt = bus.rdata;
          st_nxt = sbr_pkg::SBR_ST_IDLE;
          if (op_r == sbr_pkg::SBR_OP_ACQUIRE) begin
            owned_nxt = bus.rdata[7:0] == id_r;
          end else if ((op_r == sbr_pkg::SBR_OP_WAIT_DN
                        && bus.rdata[`SBR_ST_DNRUN])
                       || (op_r == sbr_pkg::SBR_OP_WAIT_UP
                        && bus.rdata[`SBR_ST_UPRUN])) begin
            st_nxt = sbr_pkg::SBR_ST_REQ;
          end
        end
      end
    endcase
  end

  always_comb begin
    ord_nxt = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        `SBC_OFF_TGT: ord_nxt[6:0] = tgt_r;
        `SBC_OFF_ID: ord_nxt[7:0] = id_r;
        `SBC_OFF_CMD: ord_nxt[2:0] = cmd_r;
        `SBC_OFF_DATA: ord_nxt = data_r;
        `SBC_OFF_STAT: begin
          ord_nxt[`SBC_STAT_BUSY] = st_r != sbr_pkg::SBR_ST_IDLE;
          ord_nxt[`SBC_STAT_OWNED] = owned_r;
          ord_nxt[`SBC_STAT_NACK] = nack_r;
          ord_nxt[`SBC_STAT_REFUSED] = refused_r;
        end
        `SBC_OFF_RDATA: ord_nxt = res_r;
        default: ord_nxt = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r <= sbr_pkg::SBR_ST_IDLE;
      op_r <= sbr_pkg::SBR_OP_WRITE;
      phase_r <= 1'b0;
      tgt_r <= 7'h00;
      id_r <= 8'h00;
      cmd_r <= 3'h0;
      data_r <= 16'h0000;
      owned_r <= 1'b0;
      nack_r <= 1'b0;
      refused_r <= 1'b0;
      res_r <= 16'h0000;
      req_r <= 1'b0;
      bwr_r <= 1'b0;
      bcmd_r <= 3'h0;
      bwd_r <= 16'h0000;
      dn_r <= 1'b0;
      up_r <= 1'b0;
      ord_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      phase_r <= phase_nxt;
      tgt_r <= tgt_nxt;
      id_r <= id_nxt;
      cmd_r <= cmd_nxt;
      data_r <= data_nxt;
      owned_r <= owned_nxt;
      nack_r <= nack_nxt;
      refused_r <= refused_nxt;
      res_r <= res_nxt;
      req_r <= req_nxt;
      bwr_r <= bwr_nxt;
      bcmd_r <= bcmd_nxt;
      bwd_r <= bwd_nxt;
      dn_r <= dn_nxt;
      up_r <= up_nxt;
      ord_r <= ord_nxt;
    end
  end

  assign bus.req = req_r;
  assign bus.wr = bwr_r;
  assign bus.addr = tgt_r;
  assign bus.cmd = bcmd_r;
  assign bus.wdata = bwd_r;
  assign o_rdata = ord_r;
  assign o_download_hold_cmd = dn_r;
  assign o_upload_hold_cmd = up_r;

endmodule

// *** sbr_asserts.sv ***
// interface checker for the sideband register link
`timescale 1ns/1ps
module sbr_asserts #(
  parameter logic [6:0] P_ADDR_RST = 7'h10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic req,
  input wire logic wr,
  input wire logic [6:0] addr,
  input wire logic [2:0] cmd,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  logic [6:0] slave_r;
  logic [6:0] slave_nxt;
  logic [7:0] lock_r;
  logic [7:0] lock_nxt;
  logic [2:0] rcmd_r;
  logic [2:0] rcmd_nxt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////////////
  // shadows of slave address, lock owner and last read offset
  always_comb begin
    slave_nxt = slave_r;
    lock_nxt = lock_r;
    rcmd_nxt = rcmd_r;
    if (req && ack && wr && cmd == 3'h1) begin
      slave_nxt = wdata[6:0];
    end
    if (req && ack && wr && cmd == 3'h4 &&
        (wdata[7:0] == 8'h00 || lock_r == 8'h00)) begin
      lock_nxt = wdata[7:0];
    end
    if (req && ack && !wr) begin
      rcmd_nxt = cmd;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      slave_r <= P_ADDR_RST;
      lock_r <= 8'h00;
      rcmd_r <= 3'h0;
    end else begin
      slave_r <= slave_nxt;
      lock_r <= lock_nxt;
      rcmd_r <= rcmd_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence rd_take;
    req && ack && !wr;
  endsequence
  sequence rd_done(logic [2:0] c);
    rvalid && rcmd_r == c;
  endsequence
  addr_match_a: assert property (req |-> ack == (addr == slave_r))
    else $error("ack does not follow address match");
  ack_req_a: assert property (!req |-> !ack)
    else $error("ack without request");
  read_answer_a: assert property (rd_take |=> rvalid)
    else $error("read not answered next cycle");
  answer_cause_a: assert property (rvalid |-> $past(req && ack && !wr))
    else $error("read data without read");
  lock_keep_a: assert property
    (rd_done(3'h4) |-> rdata == {8'h00, lock_r})
    else $error("lock value wrong");
  diag_upper_a: assert property
    (rd_done(3'h5) |-> rdata[15:4] == 12'h000)
    else $error("diag upper bits set");
  length_upper_a: assert property
    (rd_done(3'h6) |-> rdata[15:13] == 3'h0)
    else $error("length upper bits set");
  status_upper_a: assert property
    (rd_done(3'h2) |-> rdata[15:11] == 5'h00)
    else $error("status upper bits set");
  fifo_byte_a: assert property (rd_done(3'h0) |-> rdata[15:8] == 8'h00)
    else $error("fifo byte too wide");
endmodule

// *** smbus_sideband_registers_tb.sv ***
// self-checking bench for both ends of the sideband register link
`timescale 1ns/1ps
`include "sbr_params.svh"
module smbus_sideband_registers_tb;
  logic i_clk = 1'h0;
  logic i_srst = 1'h1;
  logic h_wr = 1'h0, h_rd = 1'h0, c_wr = 1'h0, c_rd = 1'h0;
  logic [2:0] h_cmd = 3'h0, c_addr = 3'h0;
  logic [15:0] h_wd = 16'h0000, c_wd = 16'h0000, h_q, c_q, st, r;
  logic tx_push, rx_pop, pme_n, dn_hold, up_hold;
  logic [7:0] tx_byte, rx_byte = 8'h00;
  logic [12:0] rx_len = 13'h0000;
  logic discard = 1'h0, mtx = 1'h0, rxdone = 1'h0, mask = 1'h0;
  logic wake = 1'h0, pev = 1'h0, pme_en = 1'h0, pack = 1'h0;
  // errors x4, link, negotiation, empty, download, upload, clear to send
  logic [9:0] lv = 10'h000;
  int n_errors = 0, comparisons = 0, n_push = 0, n_pop = 0;
  int n_dn = 0, n_up = 0;
  sbr_if bus_if();
  sbr_device sbr_device_i(.i_clk(i_clk), .i_srst(i_srst), .bus(bus_if.dev),
    .i_host_wr(h_wr), .i_host_rd(h_rd), .i_host_cmd(h_cmd),
    .i_host_wdata(h_wd), .o_host_rdata(h_q), .o_tx_push(tx_push),
    .o_tx_byte(tx_byte), .o_rx_pop(rx_pop), .i_rx_byte(rx_byte),
    .i_rx_len(rx_len), .i_rx_discard(discard), .i_max_coll(lv[0]),
    .i_reclaim_err(lv[1]), .i_jabber(lv[2]), .i_underrun(lv[3]),
    .i_link_up(lv[4]), .i_negotiation_done(lv[5]),
    .i_media_transmitting(mtx), .i_fifo_receive_done(rxdone),
    .i_transmit_fifo_empty(lv[6]), .i_download_running(lv[7]),
    .i_upload_running(lv[8]), .i_clear_to_send_packet(lv[9]),
    .i_wake_mask_mode(mask), .i_wake_detect(wake),
    .i_power_event_read(pev), .i_pme_enable(pme_en), .i_pme_ack(pack),
    .o_pme_n(pme_n));
  sbr_controller sbr_controller_i(.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(c_addr), .i_wdata(c_wd), .i_wr(c_wr), .i_rd(c_rd),
    .o_rdata(c_q), .o_download_hold_cmd(dn_hold),
    .o_upload_hold_cmd(up_hold), .bus(bus_if.ctl));
  sbr_asserts sbr_asserts_i(.i_clk(i_clk), .i_srst(i_srst),
    .req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr),
    .cmd(bus_if.cmd), .wdata(bus_if.wdata), .ack(bus_if.ack),
    .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (tx_push === 1'h1) n_push++;
    if (rx_pop === 1'h1) n_pop++;
    if (dn_hold === 1'h1) n_dn++;
    if (up_hold === 1'h1) n_up++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task stop_test;
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cw(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk) begin c_wr <= 1'h1; c_addr <= a; c_wd <= d; end
    @(posedge i_clk) c_wr <= 1'h0;
  endtask
  task cr(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_clk) begin c_rd <= 1'h1; c_addr <= a; end
    @(posedge i_clk) c_rd <= 1'h0;
    #1 d = c_q;
  endtask
  // one controller operation, polled until idle
  task xf(input sbr_pkg::sbr_op_e op, input logic [2:0] c,
          input logic [15:0] d);
    int i;
    cw(`SBC_OFF_CMD, {13'h0000, c});
    cw(`SBC_OFF_DATA, d);
    cw(`SBC_OFF_OP, {13'h0000, op});
    for (i = 0; i < 100; i++) begin
      cr(`SBC_OFF_STAT, st);
      if (st[`SBC_STAT_BUSY] === 1'h0) break;
    end
    if (i == 100) begin
      chk(1'h0, "controller stuck busy");
      stop_test();
    end
    cr(`SBC_OFF_RDATA, r);
  endtask
  task rd(input logic [2:0] c);
    xf(sbr_pkg::SBR_OP_READ, c, 16'h0000);
  endtask
  task wt(input logic [2:0] c, input logic [15:0] d);
    xf(sbr_pkg::SBR_OP_WRITE, c, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_addr;
    cw(`SBC_OFF_TGT, 16'h0011);
    rd(`SBR_OFF_DIAG);
    chk(st[`SBC_STAT_NACK] === 1'h1, "foreign address answered");
    cw(`SBC_OFF_TGT, 16'h0010);
    rd(`SBR_OFF_DIAG);
    chk(st[`SBC_STAT_NACK] === 1'h0, "own address refused");
    wt(`SBR_OFF_ADDR, 16'h0021);
    rd(`SBR_OFF_DIAG);
    chk(st[`SBC_STAT_NACK] === 1'h1, "old address answered");
    cw(`SBC_OFF_TGT, 16'h0021);
    rd(`SBR_OFF_ADDR);
    chk(r === 16'h0021, "new address not taken");
    wt(`SBR_OFF_ADDR, 16'h0010);
    cw(`SBC_OFF_TGT, 16'h0010);
  endtask
  task t_lock;
    cw(`SBC_OFF_ID, 16'h005A);
    xf(sbr_pkg::SBR_OP_ACQUIRE, 3'h0, 16'h0000);
    chk(st[`SBC_STAT_OWNED] === 1'h1, "lock not won");
    wt(`SBR_OFF_ARB, 16'h0033);
    rd(`SBR_OFF_ARB);
    chk(r === 16'h005A, "held lock overwritten");
    xf(sbr_pkg::SBR_OP_RELEASE, 3'h0, 16'h0000);
    rd(`SBR_OFF_ARB);
    chk(r === 16'h0000, "lock not freed");
    xf(sbr_pkg::SBR_OP_ACQUIRE, 3'h0, 16'h0000);
    chk(st[`SBC_STAT_OWNED] === 1'h1, "free lock not won");
  endtask
  task t_diag;
    wt(`SBR_OFF_DIAG, 16'hFFFF);
    rd(`SBR_OFF_DIAG);
    chk(r === 16'h000F, "diag field wrong");
    @(posedge i_clk) begin
      h_wr <= 1'h1;
      h_cmd <= `SBR_OFF_DIAG;
      h_wd <= 16'h0003;
    end
    @(posedge i_clk) begin
      h_wr <= 1'h0;
      h_rd <= 1'h1;
    end
    @(posedge i_clk) h_rd <= 1'h0;
    #1 chk(h_q === 16'h0003, "host diag access wrong");
  endtask
  task t_fifo;
    int p;
    p = n_push;
    wt(`SBR_OFF_FIFO, 16'h00A5);
    chk(n_push == p + 1 && tx_byte === 8'hA5, "push wrong");
    @(posedge i_clk) rx_byte <= 8'h3C;
    p = n_pop;
    rd(`SBR_OFF_FIFO);
    chk(n_pop == p + 1 && r === 16'h003C, "pop wrong");
    p = n_push;
    @(posedge i_clk) begin h_wr <= 1'h1; h_cmd <= 3'h0; h_wd <= 16'h0077; end
    @(posedge i_clk) begin h_wr <= 1'h0; h_rd <= 1'h1; end
    @(posedge i_clk) h_rd <= 1'h0;
    #1 chk(h_q === 16'h0000 && n_push == p, "host reached fifo");
  endtask
  task t_len;
    @(posedge i_clk) rx_len <= 13'h1FFF;
    rd(`SBR_OFF_RXLEN);
    chk(r === 16'h0000, "length moved early");
    @(posedge i_clk) discard <= 1'h1;
    @(posedge i_clk) discard <= 1'h0;
    rd(`SBR_OFF_RXLEN);
    chk(r === 16'h1FFF, "length not loaded");
  endtask
  task t_live;
    int i;
    int pos [10] = '{0, 0, 0, 0, 1, 2, 5, 6, 7, 10};
    for (i = 0; i < 10; i++) begin
      @(posedge i_clk) lv <= 10'h001 << i;
      rd(`SBR_OFF_STATUS);
      chk(r === 16'h0001 << pos[i], "live bit");
    end
    @(posedge i_clk) lv <= 10'h000;
  endtask
  task t_seen;
    @(posedge i_clk) mtx <= 1'h1;
    @(posedge i_clk) mtx <= 1'h0;
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0008, "transmit not seen");
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0000, "transmit not cleared");
    @(posedge i_clk) rxdone <= 1'h1;
    @(posedge i_clk) rxdone <= 1'h0;
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0010, "receive not seen");
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0000, "receive not cleared");
    @(posedge i_clk) begin h_rd <= 1'h1; h_cmd <= 3'h2; mtx <= 1'h1; end
    @(posedge i_clk) begin h_rd <= 1'h0; mtx <= 1'h0; end
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0008, "event lost to read");
  endtask
  task t_wake;
    @(posedge i_clk) begin pme_en <= 1'h1; mask <= 1'h1; wake <= 1'h1; end
    @(posedge i_clk) wake <= 1'h0;
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0100 && pme_n === 1'h1, "masked wake wrong");
    wt(`SBR_OFF_STATUS, 16'h0000);
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0000, "zero write kept wake");
    @(posedge i_clk) wake <= 1'h1;
    @(posedge i_clk) begin wake <= 1'h0; pev <= 1'h1; end
    @(posedge i_clk) pev <= 1'h0;
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0000, "event read kept wake");
    wt(`SBR_OFF_STATUS, 16'h0200);
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0200 && pme_n === 1'h0, "remote wake idle");
    @(posedge i_clk) pack <= 1'h1;
    @(posedge i_clk) pack <= 1'h0;
    @(posedge i_clk);
    #1 chk(pme_n === 1'h1, "remote wake stuck");
    @(posedge i_clk) begin
      mask <= 1'h0;
      wake <= 1'h1;
    end
    @(posedge i_clk) wake <= 1'h0;
    @(posedge i_clk);
    #1 chk(pme_n === 1'h0, "unmasked wake lost");
    rd(`SBR_OFF_STATUS);
    chk(r === 16'h0000, "unmasked wake pending");
  endtask
  task t_hold;
    int d, u;
    d = n_dn;
    u = n_up;
    xf(sbr_pkg::SBR_OP_WAIT_DN, 3'h0, 16'h0000);
    chk(n_dn == d + 1 && n_up == u, "download hold missing");
    xf(sbr_pkg::SBR_OP_WAIT_UP, 3'h0, 16'h0000);
    chk(n_dn == d + 1 && n_up == u + 1, "upload hold missing");
    @(posedge i_clk) lv <= 10'h080;
    cw(`SBC_OFF_OP, {13'h0000, sbr_pkg::SBR_OP_WAIT_DN});
    repeat (20) @(posedge i_clk);
    cr(`SBC_OFF_STAT, st);
    chk(st[`SBC_STAT_BUSY] === 1'h1, "download wait ended early");
    @(posedge i_clk) lv <= 10'h000;
    repeat (20) @(posedge i_clk);
    cr(`SBC_OFF_STAT, st);
    chk(st[`SBC_STAT_BUSY] === 1'h0, "download wait stuck");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'h0;
    t_addr();
    t_lock();
    t_diag();
    t_fifo();
    t_len();
    t_live();
    t_seen();
    t_wake();
    t_hold();
    stop_test();
  end
endmodule
